/* File: hdl/dl_count_top.sv */
// apb register file plus transmit and receive buffer/count tracking
// assumes apb signals are synchronous to pclk; pready is always high
//
// What this block does
// - written select bit picks transmit buffer
// - read select bit shows next free buffer
// - busy buffer makes read report other buffer
// - bos count repeats, then end interrupt, stop
// - bos count zero repeats forever
// - mos count is outgoing octet length
// - receive pointer names newest message buffer
// - bos receive count sets repeats before interrupt
// - receive count zero: no end interrupt
// - mos receive count reports stored byte size
// - type bit: 0 bit-oriented, 1 message-oriented
`timescale 1ns/1ps
`default_nettype none
module dl_count_top
    import dl_count_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_unit_done,
    output dl_count_pkg::tx_link_t tx_link,
    input wire dl_count_pkg::rx_event_t rx_event,
    output logic rx_fill_buffer,
    output logic irq
);
    import dl_count_pkg::*;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        return a == r;
    endfunction : hit

    wire setup = psel && !penable;
    wire wr = psel && penable && pwrite;
    wire sel_tx = hit(paddr, ADDR_TX_CTRL);
    wire sel_rx = hit(paddr, ADDR_RX_STAT);
    wire sel_sig = hit(paddr, ADDR_SIG_CTRL);
    wire sel_ist = hit(paddr, ADDR_IRQ_STAT);
    wire sel_msk = hit(paddr, ADDR_IRQ_MASK);
    wire mapped = sel_tx | sel_rx | sel_sig | sel_ist | sel_msk;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [6:0] tx_count_reg;
    logic tx_avail_reg;
    logic [7:0] rx_reg;
    logic [1:0] sig_reg;
    logic [IRQ_W-1:0] ist_reg, ist_next, msk_reg;
    logic [31:0] prdata_reg;
    logic tx_active, tx_buf, tx_eot;
    logic rx_commit, rx_cbuf, rx_eot;
    logic [6:0] rx_clen;

    wire tx_bos = !sig_reg[SIG_TX_BIT];
    wire rx_bos = !sig_reg[SIG_RX_BIT];
    wire wr_tx = wr && sel_tx;
    wire wr_sel = pwdata[SEL_BIT];
    // a start judges the count that arrives with it, not the stale one
    wire [6:0] tx_count_in = wr_tx ? pwdata[CNT_MSB:0] : tx_count_reg;
    // a start aimed at the buffer still being read is dropped
    wire tx_start = wr_tx && !(tx_active && wr_sel == tx_buf);
    wire tx_halt = wr && sel_sig && pwdata[SIG_HALT_BIT];
    // next free buffer: the other one while a message is in flight
    wire tx_sel_rd = tx_active ? ~tx_buf : tx_avail_reg;
    wire [7:0] tx_rd = {tx_sel_rd, tx_count_reg};
    wire [IRQ_W-1:0] ev_set = {rx_commit, rx_eot, tx_eot};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_count_reg <= TX_CTRL_RST[CNT_MSB:0];
            tx_avail_reg <= TX_CTRL_RST[SEL_BIT];
            sig_reg <= SIG_RST;
            msk_reg <= IRQ_RST;
        end else begin
            if (wr_tx) tx_count_reg <= pwdata[CNT_MSB:0];
            if (tx_start) tx_avail_reg <= ~wr_sel;
            if (wr && sel_sig) sig_reg <= pwdata[1:0];
            if (wr && sel_msk) msk_reg <= pwdata[IRQ_W-1:0];
        end
    end

    // hardware commit wins over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_reg <= RX_STAT_RST;
        end else if (rx_commit) begin
            rx_reg <= {rx_cbuf, rx_clen};
        end else if (wr && sel_rx) begin
            rx_reg <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // interrupt status: sticky, write one to clear, set wins
    // ------------------------------------------------------------
    always_comb begin
        ist_next = ist_reg;
        if (wr && sel_ist) ist_next = ist_reg & ~pwdata[IRQ_W-1:0];
        ist_next = ist_next | ev_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ist_reg <= IRQ_RST;
        else ist_reg <= ist_next;
    end

    assign irq = |(ist_reg & msk_reg);

    // ------------------------------------------------------------
    // read data, captured in the setup phase
    // ------------------------------------------------------------
    wire [31:0] rd_mux =
        sel_tx ? {24'h000000, tx_rd} :
        sel_rx ? {24'h000000, rx_reg} :
        sel_sig ? {30'h0, sig_reg} :
        sel_ist ? {29'h0, ist_reg} :
        sel_msk ? {29'h0, msk_reg} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata_reg <= 32'h00000000;
        else if (setup && !pwrite) prdata_reg <= rd_mux;
    end

    assign prdata = prdata_reg;

    // ------------------------------------------------------------
    // transmit and receive engines
    // ------------------------------------------------------------
    tx_count_ctrl u_tx (
        .pclk(pclk),
        .presetn(presetn),
        .start(tx_start),
        .start_buf(wr_sel),
        .count(tx_count_in),
        .bit_oriented_signaling(tx_bos),
        .halt(tx_halt),
        .unit_done(tx_unit_done),
        .active(tx_active),
        .buffer(tx_buf),
        .eot(tx_eot)
    );

    rx_count_track u_rx (
        .pclk(pclk),
        .presetn(presetn),
        .bit_oriented_signaling(rx_bos),
        .threshold(rx_reg[CNT_MSB:0]),
        .ev(rx_event),
        .fill_buf(rx_fill_buffer),
        .commit(rx_commit),
        .commit_buf(rx_cbuf),
        .commit_len(rx_clen),
        .eot(rx_eot)
    );

    assign tx_link.active = tx_active;
    assign tx_link.buffer = tx_buf;
    assign tx_link.bit_oriented = tx_bos;
    assign tx_link.count = tx_count_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // transmit buffer and count
    chk_tx_start_buf: assert property (
        @(posedge pclk) disable iff (!presetn)
        tx_start && !(!tx_bos && tx_count_in == CNT_ZERO)
        |=> tx_active && tx_buf == $past(wr_sel)
    ) else $error("tx buffer not taken from select write");
    chk_sel_read_free: assert property (
        @(posedge pclk) disable iff (!presetn)
        tx_active |-> tx_sel_rd != tx_buf
    ) else $error("select read reports busy buffer");
    chk_sel_read_bus: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup && !pwrite && sel_tx && tx_active
        |=> prdata[SEL_BIT] != $past(tx_buf)
    ) else $error("bus read of select shows busy buffer");
    // starting the other buffer on purpose may swap it
    chk_busy_no_switch: assert property (
        @(posedge pclk) disable iff (!presetn)
        tx_active && !tx_halt && !tx_eot && !tx_start
        ##1 tx_active |-> $stable(tx_buf)
    ) else $error("busy buffer changed under transfer");
    chk_tx_eot_stop: assert property (
        @(posedge pclk) disable iff (!presetn)
        tx_eot |-> !tx_active ##1 (!tx_eot || tx_active)
    ) else $error("transmit kept sending after end");
    chk_tx_spurious_end: assert property (
        @(posedge pclk) disable iff (!presetn)
        !tx_active |=> !tx_eot
    ) else $error("transmit end raised with nothing in flight");
    // mask or status writes right after the end would break this one
    chk_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        tx_eot && msk_reg[IRQ_TX_EOT] |=> irq [*2]
    ) else $error("unmasked event did not hold irq");
    chk_bos_forever: assert property (
        @(posedge pclk) disable iff (!presetn)
        tx_active && tx_bos && tx_count_reg == CNT_ZERO && !tx_halt
        && !wr_tx |=> tx_active && !tx_eot
    ) else $error("zero count bos stopped");
    chk_halt_stops: assert property (
        @(posedge pclk) disable iff (!presetn)
        tx_halt |=> !tx_active
    ) else $error("halt did not stop the transmitter");
    chk_tx_count_store: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_tx |=> tx_link.count == $past(pwdata[CNT_MSB:0])
    ) else $error("written count not kept");
    chk_mos_zero_idle: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_tx && !tx_bos && pwdata[CNT_MSB:0] == CNT_ZERO && !tx_active
        |=> !tx_active
    ) else $error("empty message started a transfer");
    chk_type_follows: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && sel_sig
        |=> tx_link.bit_oriented == !$past(pwdata[SIG_TX_BIT])
    ) else $error("signaling type not taken from type bit");

    // receive pointer and count
    chk_rx_fill_swap: assert property (
        @(posedge pclk) disable iff (!presetn)
        rx_commit |-> rx_fill_buffer != rx_cbuf
    ) else $error("pointer names the buffer being filled");
    chk_rx_sw_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && sel_rx && !rx_commit
        |=> rx_reg == $past(pwdata[7:0])
    ) else $error("receive threshold write lost");
    chk_rx_eot_count: assert property (
        @(posedge pclk) disable iff (!presetn)
        rx_eot |-> $past(rx_bos)
        && $past(rx_reg[CNT_MSB:0]) != CNT_ZERO
    ) else $error("receive end without bos threshold");
    chk_rx_zero_noeot: assert property (
        @(posedge pclk) disable iff (!presetn)
        rx_bos && rx_reg[CNT_MSB:0] == CNT_ZERO |=> !rx_eot
    ) else $error("receive end raised with zero count");
    chk_rx_mos_only: assert property (
        @(posedge pclk) disable iff (!presetn)
        rx_commit |-> !$past(rx_bos)
    ) else $error("message size committed in bos mode");
    chk_rx_pair: assert property (
        @(posedge pclk) disable iff (!presetn)
        rx_commit |=> rx_reg == {$past(rx_cbuf), $past(rx_clen)}
    ) else $error("pointer and count not updated together");
    chk_rx_read_pair: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup && !pwrite && sel_rx
        |=> prdata[7:0] == $past(rx_reg)
    ) else $error("receive register read split");

    // interrupt status
    chk_tx_end_irq: assert property (
        @(posedge pclk) disable iff (!presetn)
        tx_eot |=> ist_reg[IRQ_TX_EOT]
    ) else $error("transmit end not latched");
    chk_commit_irq: assert property (
        @(posedge pclk) disable iff (!presetn)
        rx_commit |=> ist_reg[IRQ_RX_MSG]
    ) else $error("message commit not latched");
    chk_irq_w1c: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && sel_ist && ev_set == IRQ_RST
        |=> (ist_reg & $past(pwdata[IRQ_W-1:0])) == IRQ_RST
    ) else $error("status bit not cleared by write one");
    chk_set_wins: assert property (
        @(posedge pclk) disable iff (!presetn)
        ev_set != IRQ_RST |=> (ist_reg & $past(ev_set)) == $past(ev_set)
    ) else $error("event lost against status clear");

    // ------------------------------------------------------------
    // scenarios the bench must reach
    // ------------------------------------------------------------
    cov_tx_eot: cover property (@(posedge pclk) disable iff (!presetn)
        tx_active ##[1:200] tx_eot);
    cov_rx_commit: cover property (@(posedge pclk) disable iff (!presetn)
        rx_commit ##[1:200] rx_commit);
    cov_rx_eot: cover property (@(posedge pclk) disable iff (!presetn)
        rx_eot ##1 irq);
    cov_tx_refused: cover property (@(posedge pclk) disable iff (!presetn)
        tx_active && wr_tx && !tx_start);
    cov_bos_halt: cover property (@(posedge pclk) disable iff (!presetn)
        tx_halt && tx_active && tx_bos);
endmodule : dl_count_top
`default_nettype wire

/* File: hdl/dl_count_pkg.sv */
// constants and carrier types for the data-link buffer and count block
// assumes a 32-bit apb with one register per aligned word
package dl_count_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_TX_CTRL = 12'h000;
    localparam logic [11:0] ADDR_RX_STAT = 12'h004;
    localparam logic [11:0] ADDR_SIG_CTRL = 12'h008;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h00c;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int SEL_BIT = 7;
    localparam int CNT_MSB = 6;
    localparam int SIG_TX_BIT = 0;
    localparam int SIG_RX_BIT = 1;
    localparam int SIG_HALT_BIT = 2;
    localparam int IRQ_TX_EOT = 0;
    localparam int IRQ_RX_EOT = 1;
    localparam int IRQ_RX_MSG = 2;
    localparam int IRQ_W = 3;
    localparam logic [7:0] TX_CTRL_RST = 8'h00;
    localparam logic [7:0] RX_STAT_RST = 8'h00;
    localparam logic [1:0] SIG_RST = 2'h0;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
    localparam logic [6:0] CNT_ZERO = 7'h00;
    localparam logic [6:0] CNT_ONE = 7'h01;
    localparam logic [6:0] CNT_MAX = 7'h7f;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic byte_wr;
        logic msg_end;
        logic bos_rep;
    } rx_event_t;
    typedef struct packed {
        logic active;
        logic buffer;
        logic bit_oriented;
        logic [6:0] count;
    } tx_link_t;
endpackage : dl_count_pkg

/* File: hdl/tx_count_ctrl.sv */
// transmit side: tracks the buffer in use and counts octets or repeats
// assumes unit_done pulses once per octet read or per repetition sent
`timescale 1ns/1ps
`default_nettype none
module tx_count_ctrl
    import dl_count_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic start_buf,
    input wire logic [6:0] count,
    input wire logic bit_oriented_signaling,
    input wire logic halt,
    input wire logic unit_done,
    output logic active,
    output logic buffer,
    output logic eot
);
    logic active_reg, active_next, buf_reg, eot_reg, eot_next;
    logic [6:0] done_reg, done_next;
    wire [6:0] done_inc = done_reg + CNT_ONE;
    // zero count in bit-oriented mode never reaches the end
    wire last = unit_done && active_reg && count != CNT_ZERO
                && done_inc == count;
    // a zero-length message has nothing to read out
    wire go = start && !(bit_oriented_signaling == 1'b0 && count == CNT_ZERO);

    always_comb begin
        active_next = active_reg;
        done_next = done_reg;
        eot_next = 1'b0;
        if (go) begin
            active_next = 1'b1;
            done_next = CNT_ZERO;
        end else if (halt) begin
            active_next = 1'b0;
        end else if (last) begin
            active_next = 1'b0;
            eot_next = 1'b1;
        end else if (unit_done && active_reg) begin
            done_next = done_inc;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_reg <= 1'b0;
            buf_reg <= 1'b0;
            done_reg <= CNT_ZERO;
            eot_reg <= 1'b0;
        end else begin
            active_reg <= active_next;
            done_reg <= done_next;
            eot_reg <= eot_next;
            if (go) buf_reg <= start_buf;
        end
    end

    assign active = active_reg;
    assign buffer = buf_reg;
    assign eot = eot_reg;
endmodule : tx_count_ctrl
`default_nettype wire

/* File: hdl/rx_count_track.sv */
// receive side: counts bytes of a message or bos repetitions
// assumes events come from the receive controller, one per cycle each
`timescale 1ns/1ps
`default_nettype none
module rx_count_track
    import dl_count_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic bit_oriented_signaling,
    input wire logic [6:0] threshold,
    input wire dl_count_pkg::rx_event_t ev,
    output logic fill_buf,
    output logic commit,
    output logic commit_buf,
    output logic [6:0] commit_len,
    output logic eot
);
    logic fill_reg, commit_reg, cbuf_reg, eot_reg;
    logic [6:0] bytes_reg, reps_reg, len_reg;
    // byte arriving with the end marker still belongs to the message
    wire [6:0] bytes_inc = (bytes_reg == CNT_MAX) ? CNT_MAX
                           : bytes_reg + CNT_ONE;
    wire [6:0] bytes_now = ev.byte_wr ? bytes_inc : bytes_reg;
    wire [6:0] reps_inc = reps_reg + CNT_ONE;
    wire mos_end = !bit_oriented_signaling && ev.msg_end;
    wire rep_hit = bit_oriented_signaling && ev.bos_rep && threshold != CNT_ZERO
                   && reps_inc == threshold;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_reg <= 1'b0;
            commit_reg <= 1'b0;
            cbuf_reg <= 1'b0;
            len_reg <= CNT_ZERO;
            bytes_reg <= CNT_ZERO;
            reps_reg <= CNT_ZERO;
            eot_reg <= 1'b0;
        end else begin
            commit_reg <= mos_end;
            eot_reg <= rep_hit;
            if (mos_end) begin
                cbuf_reg <= fill_reg;
                len_reg <= bytes_now;
                fill_reg <= ~fill_reg;
                bytes_reg <= CNT_ZERO;
            end else if (!bit_oriented_signaling && ev.byte_wr) begin
                bytes_reg <= bytes_inc;
            end
            if (!bit_oriented_signaling || rep_hit) reps_reg <= CNT_ZERO;
            else if (ev.bos_rep) reps_reg <= reps_inc;
        end
    end

    assign fill_buf = fill_reg;
    assign commit = commit_reg;
    assign commit_buf = cbuf_reg;
    assign commit_len = len_reg;
    assign eot = eot_reg;
endmodule : rx_count_track
`default_nettype wire

/* File: bench/dl_far_end.sv */
// far-end terminal model: takes transmit units, sends receive traffic
// assumes the bench pulses rx_go for one cycle with rx_n and rx_bos set
`timescale 1ns/1ps
`default_nettype none
module dl_far_end
    import dl_count_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire dl_count_pkg::tx_link_t tx_link,
    input wire logic stall,
    input wire logic slow,
    input wire logic rx_go,
    input wire logic rx_bos,
    input wire logic [6:0] rx_n,
    output logic tx_unit_done,
    output dl_count_pkg::rx_event_t rx_event,
    output logic rx_busy
);
    logic [1:0] gap_reg;
    logic [6:0] left_reg;
    logic fire;
    // slow mode spaces units four cycles apart, prompt every other cycle
    assign fire = slow ? (gap_reg == 2'h3) : !tx_unit_done;
    assign rx_busy = (left_reg != 7'h00);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_unit_done <= 1'b0;
            gap_reg <= 2'h0;
            left_reg <= 7'h00;
            rx_event <= '0;
        end else begin
            gap_reg <= gap_reg + 2'h1;
            tx_unit_done <= tx_link.active && !stall && fire;
            left_reg <= rx_go ? rx_n : (rx_busy ? left_reg - 7'h01 : 7'h00);
            rx_event.byte_wr <= !rx_bos && rx_busy;
            rx_event.msg_end <= !rx_bos && (left_reg == 7'h01);
            rx_event.bos_rep <= rx_bos && rx_busy;
        end
    end
endmodule : dl_far_end
`default_nettype wire

/* File: bench/hdlc_datalink_buffer_count_tb.sv */
// self-checking bench for the data-link buffer and count block
// assumes dl_far_end stands in for the remote terminal equipment
`timescale 1ns/1ps
`default_nettype none
module hdlc_datalink_buffer_count_tb;
    import dl_count_pkg::*;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic tx_unit_done, rx_fill_buffer, stall, rx_go, rx_bos, rx_busy, sel;
    logic [6:0] rx_n, n;
    tx_link_t tx_link;
    rx_event_t rx_event;
    int err_count, checks_done, units, i;
    always #10 pclk = ~pclk;
    dl_count_top i_dl_count_top (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_unit_done(tx_unit_done), .tx_link(tx_link),
        .rx_event(rx_event), .rx_fill_buffer(rx_fill_buffer), .irq(irq));
    dl_far_end i_dl_far_end (.pclk(pclk), .presetn(presetn),
        .tx_link(tx_link), .stall(stall), .slow(i[0]), .rx_go(rx_go),
        .rx_bos(rx_bos), .rx_n(rx_n), .tx_unit_done(tx_unit_done),
        .rx_event(rx_event), .rx_busy(rx_busy));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    task automatic tmo();
        err_count++;
        stop_test();
    endtask : tmo
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) tmo();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic stat(input int b, input logic e);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        check(rd[b], e);
    endtask : stat
    // active drops the cycle after the last unit, so units counted here
    // are exactly those the transmitter accepted
    task automatic wait_tx();
        int k;
        units = 0;
        for (k = 0; k < 1000; k++) begin
            @(posedge pclk);
            if (tx_link.active !== 1'b1) break;
            if (tx_unit_done === 1'b1) units++;
        end
        if (k == 1000) tmo();
    endtask : wait_tx
    task automatic send_rx(input logic b, input logic [6:0] cnt);
        int k;
        @(posedge pclk);
        rx_bos <= b;
        rx_n <= cnt;
        rx_go <= 1'b1;
        @(posedge pclk);
        rx_go <= 1'b0;
        for (k = 0; k < 200; k++) begin
            @(posedge pclk);
            if (rx_busy === 1'b0) break;
        end
        if (k == 200) tmo();
        // commit lands two edges after the last event
        repeat (4) @(posedge pclk);
    endtask : send_rx
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, stall, rx_go, rx_bos} = '0;
        {paddr, pwdata, rx_n, i, err_count, checks_done} = '0;
        void'($urandom(2));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_TX_CTRL, 32'h0);
        check(rd[6:0], CNT_ZERO);
        apb(1'b0, ADDR_RX_STAT, 32'h0);
        check(rd, {24'h0, RX_STAT_RST});
        check(tx_link.bit_oriented, 1'b1);
        $display("test reset done");
        // both buffers, both types, random counts from 1 to 12 and full count
        for (i = 0; i < 6; i++) begin
            sel = i[0];
            n = (i == 2) ? CNT_MAX : 7'($urandom_range(1, 12));
            stall <= 1'b1;
            apb(1'b1, ADDR_IRQ_MASK, {29'h0, 2'b11, 1'(i != 5)});
            apb(1'b1, ADDR_SIG_CTRL, {31'h0, 1'(i < 3)});
            apb(1'b1, ADDR_TX_CTRL, {24'h0, sel, n});
            @(posedge pclk);
            check(tx_link.active, 1'b1);
            check(tx_link.buffer, sel);
            check(tx_link.bit_oriented, 1'(i >= 3));
            check(tx_link.count, n);
            if (i == 1) begin
                apb(1'b1, ADDR_TX_CTRL, {24'h0, sel, n});
                check(tx_link.buffer, sel);
            end
            apb(1'b0, ADDR_TX_CTRL, 32'h0);
            check(rd[7], !sel);
            stall <= 1'b0;
            wait_tx();
            check(units, n);
            stat(IRQ_TX_EOT, 1'b1);
            check(irq, 1'(i != 5));
            apb(1'b1, ADDR_IRQ_STAT, 32'h7);
            apb(1'b0, ADDR_TX_CTRL, 32'h0);
            check(rd[7], !sel);
            check(irq, 1'b0);
        end
        $display("test transmit counts done");
        apb(1'b1, ADDR_SIG_CTRL, 32'h0);
        apb(1'b1, ADDR_TX_CTRL, 32'h80);
        repeat (60) @(posedge pclk);
        check(tx_link.active, 1'b1);
        apb(1'b1, ADDR_SIG_CTRL, 32'h4);
        wait_tx();
        apb(1'b1, ADDR_IRQ_STAT, 32'h7);
        $display("test endless repeat done");
        // message receive: pointer and size move together
        apb(1'b1, ADDR_SIG_CTRL, 32'h2);
        for (i = 0; i < 3; i++) begin
            n = (i == 2) ? CNT_ONE : 7'($urandom_range(2, 40));
            send_rx(1'b0, n);
            apb(1'b0, ADDR_RX_STAT, 32'h0);
            check(rd[7], i[0]);
            check(rd[7:0], {i[0], n});
            check(rx_fill_buffer, !i[0]);
            stat(IRQ_RX_MSG, 1'b1);
            apb(1'b1, ADDR_IRQ_STAT, 32'h7);
        end
        $display("test message receive done");
        apb(1'b1, ADDR_SIG_CTRL, 32'h0);
        n = 7'($urandom_range(2, 9));
        apb(1'b1, ADDR_RX_STAT, {25'h0, n});
        send_rx(1'b1, n - 7'h01);
        stat(IRQ_RX_EOT, 1'b0);
        send_rx(1'b1, CNT_ONE);
        stat(IRQ_RX_EOT, 1'b1);
        apb(1'b1, ADDR_IRQ_STAT, 32'h7);
        apb(1'b1, ADDR_RX_STAT, 32'h0);
        send_rx(1'b1, 7'h0a);
        stat(IRQ_RX_EOT, 1'b0);
        apb(1'b0, 12'h020, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        $display("test repeat receive done");
        stop_test();
    end
endmodule : hdlc_datalink_buffer_count_tb
`default_nettype wire
